// File: hw/esvb_defs.svh
// Register offsets, field positions and reset values for the exception state block.
`ifndef ESVB_DEFS_SVH
`define ESVB_DEFS_SVH

// ****************************************************************
// Bus geometry and responses
// ****************************************************************
`define ESVB_ADDR_W           8
`define ESVB_RESP_OKAY        2'h0
`define ESVB_RESP_SLVERR      2'h2

// ****************************************************************
// Register offsets
// ****************************************************************
`define ESVB_STATE_OFFSET     8'h00
`define ESVB_VBASE_OFFSET     8'h04

// ****************************************************************
// State register fields
// ****************************************************************
`define ESVB_SVC_SET_BIT      28
`define ESVB_SVC_CLR_BIT      27
`define ESVB_TICK_SET_BIT     26
`define ESVB_TICK_CLR_BIT     25
`define ESVB_PEND_BYTE        3

// ****************************************************************
// Exception numbers and vector base masks
// ****************************************************************
`define ESVB_EXC_NMI          9'h002
`define ESVB_EXC_HARDFAULT    9'h003
`define ESVB_EXC_FIRST_CFG    9'h004
`define ESVB_EXC_SVC_PEND     9'h00e
`define ESVB_EXC_TICK         9'h00f
`define ESVB_EXC_FIRST_IRQ    16
`define ESVB_VBASE_MASK_NAR   32'h3fffff80
`define ESVB_VBASE_MASK_WIDE  32'hffffff80
`define ESVB_VBASE_RESET      32'h00000000

`endif

// File: hw/esvb_pkg.sv
// Types shared by the exception state block and its priority picker.
package esvb_pkg;

  // ****************************************************************
  // Core side status carrier
  // ****************************************************************
  typedef struct packed {
    logic       debug_halted;
    logic       all_fault_block;
    logic [7:0] threshold_priority_mask;
    logic [8:0] program_status_exception_field;
    logic       entry_valid;
    logic [8:0] entry_number;
  } esvb_core_t;

  // ****************************************************************
  // Picker result carrier
  // ****************************************************************
  typedef struct packed {
    logic       found;
    logic [5:0] number;
  } esvb_pick_t;

endpackage : esvb_pkg

// File: hw/esvb_pick.sv
// Combinational selection of the highest-priority pending enabled exception.
`timescale 1ns/100ps
`default_nettype none
`include "esvb_defs.svh"

module esvb_pick #(
  parameter int NUM_EXC = 64
) (
  input  wire logic [NUM_EXC-1:0]   pending,
  input  wire logic [NUM_EXC-1:0]   enabled,
  input  wire logic [NUM_EXC*8-1:0] priority_flat,
  input  wire logic [7:0]           threshold,
  input  wire logic                 fault_block,
  output esvb_pkg::esvb_pick_t      result
);

  // ****************************************************************
  // Scan
  // ****************************************************************
  // Ascending scan with a strict compare lets the lower number win a tie.
  always_comb begin
    logic [8:0] best;
    logic [8:0] cand;
    logic [7:0] prio;
    logic       elig;
    cand   = 9'h000;
    prio   = 8'h00;
    elig   = 1'b0;
    best   = 9'h1ff;
    result = '0;
    for (int i = 2; i < NUM_EXC; i++) begin
      prio = priority_flat[i*8 +: 8];
      if (9'(i) == `ESVB_EXC_NMI) begin
        cand = 9'h000;
      end else if (9'(i) == `ESVB_EXC_HARDFAULT) begin
        cand = 9'h001;
      end else begin
        cand = {1'b0, prio} + 9'h002;
      end
      elig = pending[i] && enabled[i];
      if (fault_block && 9'(i) != `ESVB_EXC_NMI) begin
        elig = 1'b0;
      end
      if (threshold != 8'h00 && 9'(i) >= `ESVB_EXC_FIRST_CFG && prio >= threshold) begin
        elig = 1'b0;
      end
      if (elig && cand < best) begin
        best          = cand;
        result.found  = 1'b1;
        result.number = 6'(i);
      end
    end
  end

endmodule : esvb_pick
`default_nettype wire

// File: hw/esvb_ctrl.sv
// Exception state register and vector base register behind an AXI4-Lite slave.
`timescale 1ns/100ps
`default_nettype none
`include "esvb_defs.svh"

module esvb_ctrl #(
  parameter int NUM_IRQ     = 48,
  parameter bit WIDE_OFFSET = 1'b0
) (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic [`ESVB_ADDR_W-1:0]       s_axi_awaddr,
  input  wire logic [2:0]                    s_axi_awprot,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [`ESVB_ADDR_W-1:0]       s_axi_araddr,
  input  wire logic [2:0]                    s_axi_arprot,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire esvb_pkg::esvb_core_t          core_status,
  input  wire logic                          tick_event,
  input  wire logic [16+NUM_IRQ-1:0]         exc_pending,
  input  wire logic [16+NUM_IRQ-1:0]         exc_enabled,
  input  wire logic [16+NUM_IRQ-1:0]         exc_active,
  input  wire logic [(16+NUM_IRQ)*8-1:0]     exc_priority,
  output logic                               service_call_pending,
  output logic                               tick_pending,
  output logic                               irq_pending_flag,
  output logic [5:0]                         highest_pending_number,
  output logic [31:0]                        vector_table_base,
  output logic                               table_region_bit
);

  localparam int NUM_EXC = 16 + NUM_IRQ;

  // ****************************************************************
  // Write channel capture
  // ****************************************************************
  logic                     aw_held;
  logic [`ESVB_ADDR_W-1:0]  aw_addr;
  logic                     w_held;
  logic [31:0]              w_data;
  logic [3:0]               w_strb;
  logic [31:0]              vector_base_register;

  wire aw_take  = s_axi_awvalid && s_axi_awready;
  wire w_take   = s_axi_wvalid && s_axi_wready;
  wire b_done   = s_axi_bvalid && s_axi_bready;
  wire wr_fire  = aw_held && w_held && !s_axi_bvalid;
  wire wr_state = wr_fire && aw_addr[`ESVB_ADDR_W-1:2] == `ESVB_STATE_OFFSET >> 2;
  wire wr_vbase = wr_fire && aw_addr[`ESVB_ADDR_W-1:2] == `ESVB_VBASE_OFFSET >> 2;
  wire wr_hit   = wr_state || wr_vbase;
  wire pend_we  = wr_state && w_strb[`ESVB_PEND_BYTE];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (aw_take) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (w_take) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  // Ready is withheld while a captured beat waits for its write, not while only a response waits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_take && !(aw_held && !b_done) && !wr_fire;
      s_axi_wready  <= !w_take && !(w_held && !b_done) && !wr_fire;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `ESVB_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? `ESVB_RESP_OKAY : `ESVB_RESP_SLVERR;
    end else if (b_done) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Pending state of the two pendable system exceptions
  // ****************************************************************
  wire entry_svc  = core_status.entry_valid && core_status.entry_number == `ESVB_EXC_SVC_PEND;
  wire entry_tick = core_status.entry_valid && core_status.entry_number == `ESVB_EXC_TICK;
  wire svc_set    = pend_we && w_data[`ESVB_SVC_SET_BIT];
  wire svc_clr    = (pend_we && w_data[`ESVB_SVC_CLR_BIT]) || entry_svc;
  wire tick_set   = (pend_we && w_data[`ESVB_TICK_SET_BIT]) || tick_event;
  wire tick_clr   = (pend_we && w_data[`ESVB_TICK_CLR_BIT]) || entry_tick;

  // A set arriving with a clear wins, so no event is lost to a racing clear.
  wire next_svc_pending  = svc_set || (service_call_pending && !svc_clr);
  wire next_tick_pending = tick_set || (tick_pending && !tick_clr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      service_call_pending <= 1'b0;
      tick_pending         <= 1'b0;
    end else begin
      service_call_pending <= next_svc_pending;
      tick_pending         <= next_tick_pending;
    end
  end

  // ****************************************************************
  // Vector base register
  // ****************************************************************
  localparam logic [31:0] VBASE_MASK = WIDE_OFFSET ? `ESVB_VBASE_MASK_WIDE
                                                   : `ESVB_VBASE_MASK_NAR;

  logic [31:0] next_vector_base;
  always_comb begin
    next_vector_base = vector_base_register;
    for (int b = 0; b < 4; b++) begin
      if (w_strb[b]) begin
        next_vector_base[b*8 +: 8] = w_data[b*8 +: 8];
      end
    end
    next_vector_base = next_vector_base & VBASE_MASK;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vector_base_register <= `ESVB_VBASE_RESET;
    end else if (wr_vbase) begin
      vector_base_register <= next_vector_base;
    end
  end

  // The table base is the register value itself, counted from address zero.
  wire next_region = WIDE_OFFSET ? next_vector_base[31] : next_vector_base[29];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vector_table_base <= `ESVB_VBASE_RESET;
      table_region_bit  <= 1'b0;
    end else if (wr_vbase) begin
      vector_table_base <= next_vector_base;
      table_region_bit  <= next_region;
    end
  end

  // ****************************************************************
  // Exception status
  // ****************************************************************
  logic [NUM_EXC-1:0]   pend_all;
  logic [NUM_EXC-1:0]   enab_all;
  esvb_pkg::esvb_pick_t pick;

  always_comb begin
    pend_all     = exc_pending;
    enab_all     = exc_enabled;
    pend_all[14] = service_call_pending;
    pend_all[15] = tick_pending;
    enab_all[14] = 1'b1;
    enab_all[15] = 1'b1;
  end

  // The priority picker is wired in here with all exception priorities.
  esvb_pick #(
    .NUM_EXC       (NUM_EXC)
  ) u_pick (
    .pending       (pend_all),
    .enabled       (enab_all),
    .priority_flat (exc_priority),
    .threshold     (core_status.threshold_priority_mask),
    .fault_block   (core_status.all_fault_block),
    .result        (pick)
  );

  wire [5:0] next_highest = pick.found ? pick.number : 6'h00;
  wire       next_irq     = |exc_pending[NUM_EXC-1:`ESVB_EXC_FIRST_IRQ];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      highest_pending_number <= 6'h00;
      irq_pending_flag       <= 1'b0;
    end else begin
      highest_pending_number <= next_highest;
      irq_pending_flag       <= next_irq;
    end
  end

  // At most one active bit means nothing preempted waits underneath.
  wire [NUM_EXC-1:0] act_less = exc_active - NUM_EXC'(1);
  wire               ret_base = (exc_active & act_less) == '0;
  wire [8:0]         active_n = core_status.program_status_exception_field;
  wire               dbg_bit  = core_status.debug_halted && next_irq;

  // Reserved positions and both write-only clear bits read as zero.
  wire [31:0] state_rd = {3'h0, service_call_pending, 1'b0, tick_pending,
                          1'b0, 1'b0, dbg_bit, irq_pending_flag, 4'h0,
                          highest_pending_number, ret_base, 2'h0,
                          active_n};

  // ****************************************************************
  // Read channel
  // ****************************************************************
  wire ar_take  = s_axi_arvalid && s_axi_arready;
  wire r_done   = s_axi_rvalid && s_axi_rready;
  wire rd_state = s_axi_araddr[`ESVB_ADDR_W-1:2] == `ESVB_STATE_OFFSET >> 2;
  wire rd_vbase = s_axi_araddr[`ESVB_ADDR_W-1:2] == `ESVB_VBASE_OFFSET >> 2;

  wire [31:0] rd_mux  = rd_state ? state_rd
                      : rd_vbase ? vector_base_register : 32'h00000000;
  wire [1:0]  rd_resp = (rd_state || rd_vbase) ? `ESVB_RESP_OKAY : `ESVB_RESP_SLVERR;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !ar_take && !(s_axi_rvalid && !r_done);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `ESVB_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_resp;
    end else if (r_done) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : esvb_ctrl
`default_nettype wire

// File: tb/esvb_ctrl_monitor.sv
// Concurrent checks on the ports of the exception state block.
`timescale 1ns/100ps
`default_nettype none
`include "esvb_defs.svh"

module esvb_ctrl_monitor #(
  parameter int NUM_IRQ     = 48,
  parameter bit WIDE_OFFSET = 1'b0
) (
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire logic [7:0]           s_axi_awaddr,
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_awready,
  input wire logic [31:0]          s_axi_wdata,
  input wire logic [3:0]           s_axi_wstrb,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_wready,
  input wire logic                 s_axi_bvalid,
  input wire logic [7:0]           s_axi_araddr,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic [31:0]          s_axi_rdata,
  input wire esvb_pkg::esvb_core_t core_status,
  input wire logic                 tick_event,
  input wire logic [16+NUM_IRQ-1:0] exc_pending,
  input wire logic [16+NUM_IRQ-1:0] exc_enabled,
  input wire logic [16+NUM_IRQ-1:0] exc_active,
  input wire logic                 service_call_pending,
  input wire logic                 tick_pending,
  input wire logic                 irq_pending_flag,
  input wire logic [5:0]           highest_pending_number,
  input wire logic [31:0]          vector_table_base,
  input wire logic                 table_region_bit
);
  logic [7:0]  aw_q;
  logic [31:0] w_q;
  logic [3:0]  s_q;
  logic        one_active;
  assign one_active = ($countones(exc_active) <= 1);
  // Address and data are kept because the write lands well after they were taken.
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) w_q <= s_axi_wdata;
    if (s_axi_wvalid && s_axi_wready) s_q <= s_axi_wstrb;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence state_read;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == `ESVB_STATE_OFFSET;
  endsequence
  sequence write_done;
    $rose(s_axi_bvalid);
  endsequence
  AST_IRQ_FLAG: assert property ($past(aresetn, 2) |->
    irq_pending_flag == $past(|exc_pending[16+NUM_IRQ-1:16])) else $error("irq flag wrong");
  AST_PICK_NONE: assert property ($past(aresetn, 2) && $past(exc_pending == '0
    && !tick_pending && !service_call_pending) |-> highest_pending_number == 6'h00)
    else $error("highest not zero");
  AST_FAULT_NMI: assert property ($past(aresetn, 2) && $past(core_status.all_fault_block
    && exc_pending[2] && exc_enabled[2]) |-> highest_pending_number == 6'h02)
    else $error("fault block pick wrong");
  AST_TICK_SET: assert property (tick_event |=> tick_pending) else $error("tick not set");
  AST_TICK_CLR: assert property (write_done ##0 (aw_q == `ESVB_STATE_OFFSET && w_q[25]
    && s_q[3] && !w_q[26] && !$past(tick_event)) |-> !tick_pending) else $error("tick not cleared");
  AST_SVC_SET: assert property (write_done ##0 (aw_q == `ESVB_STATE_OFFSET && w_q[28]
    && s_q[3]) |-> service_call_pending) else $error("service call not set");
  AST_VBASE: assert property (write_done ##0 (aw_q == `ESVB_VBASE_OFFSET
    && s_q == 4'hf) |->
    vector_table_base == (w_q & (WIDE_OFFSET ? `ESVB_VBASE_MASK_WIDE : `ESVB_VBASE_MASK_NAR))
    && table_region_bit == w_q[WIDE_OFFSET ? 31 : 29]) else $error("vector base wrong");
  AST_ACTIVE: assert property (state_read |=>
    s_axi_rdata[8:0] == $past(core_status.program_status_exception_field))
    else $error("active number wrong");
  AST_RET_BASE: assert property (state_read |=> s_axi_rdata[11] == $past(one_active))
    else $error("return to base wrong");
  AST_DEBUG: assert property (state_read ##0 !core_status.debug_halted |=> !s_axi_rdata[23])
    else $error("debug bit set");
  AST_RSVD: assert property (state_read |=> s_axi_rdata[24] == 1'b0
    && s_axi_rdata[21:18] == 4'h0 && s_axi_rdata[10:9] == 2'h0) else $error("reserved set");
endmodule : esvb_ctrl_monitor

bind esvb_ctrl esvb_ctrl_monitor #(.NUM_IRQ(NUM_IRQ), .WIDE_OFFSET(WIDE_OFFSET))
  i_esvb_ctrl_monitor (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .core_status(core_status), .tick_event(tick_event),
  .exc_pending(exc_pending), .exc_enabled(exc_enabled), .exc_active(exc_active),
  .service_call_pending(service_call_pending), .tick_pending(tick_pending),
  .irq_pending_flag(irq_pending_flag), .highest_pending_number(highest_pending_number),
  .vector_table_base(vector_table_base), .table_region_bit(table_region_bit));
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the exception state and vector base block.
`timescale 1ns/100ps
`default_nettype none
`include "esvb_defs.svh"

module tb_top;
  localparam int         NEXC = 32;
  localparam logic [7:0] ST   = `ESVB_STATE_OFFSET;
  localparam logic [7:0] VB   = `ESVB_VBASE_OFFSET;
  logic                 aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, tick_event;
  logic                 awready, wready, bvalid, arready, rvalid, svc_p, tick_p, irq_f, region;
  logic [7:0]           awaddr, araddr;
  logic [31:0]          wdata, rdata, vbase, d;
  logic [1:0]           bresp, rresp;
  logic [3:0]           strb;
  logic [5:0]           highest;
  logic [NEXC-1:0]      pend, enab, act;
  logic [NEXC*8-1:0]    prio;
  esvb_pkg::esvb_core_t core;
  int                   n_mismatch, num_checks;

  esvb_ctrl #(.NUM_IRQ(NEXC-16)) i_esvb_ctrl (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .core_status(core),
    .tick_event(tick_event), .exc_pending(pend), .exc_enabled(enab), .exc_active(act),
    .exc_priority(prio), .service_call_pending(svc_p), .tick_pending(tick_p),
    .irq_pending_flag(irq_f), .highest_pending_number(highest), .vector_table_base(vbase),
    .table_region_bit(region));

  // ****
  // Shared tasks
  // ****
  task automatic conclude();
    if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  task automatic give_up();
    n_mismatch++;
    $display("[FAIL] %0t no answer from the bus", $time);
    conclude();
  endtask : give_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic settle();
    repeat (2) @(posedge aclk);
  endtask : settle
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int k = 0; k < 40 && !done; k++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        chk(32'(bresp), 32'(er));
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) give_up();
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
    logic done;
    done = 1'b0;
    v = 32'h0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int k = 0; k < 40 && !done; k++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        chk(32'(rresp), 32'(er));
        v = rdata;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) give_up();
  endtask : rd

  // ****
  // Scenarios
  // ****
  task automatic s_reset();
    rd(ST, 2'h0, d);
    chk(d, 32'h00000800);
    rd(VB, 2'h0, d);
    chk(d, `ESVB_VBASE_RESET);
    wr(8'h08, 32'hffffffff, 2'h2);
    rd(8'h08, 2'h2, d);
    chk(d, 32'h0);
  endtask : s_reset
  task automatic s_tick();
    tick_event <= 1'b1;
    @(posedge aclk);
    tick_event <= 1'b0;
    settle();
    chk(32'(tick_p), 32'h1);
    wr(ST, 32'h0, 2'h0);
    chk(32'(tick_p), 32'h1);
    wr(ST, 32'h02000000, 2'h0);
    chk(32'(tick_p), 32'h0);
    wr(ST, 32'h04000000, 2'h0);
    rd(ST, 2'h0, d);
    chk(32'(d[26]), 32'h1);
    wr(ST, 32'h02000000, 2'h0);
    rd(ST, 2'h0, d);
    chk(32'(d[26]), 32'h0);
    strb <= 4'h7;
    wr(ST, 32'h04000000, 2'h0);
    chk(32'(tick_p), 32'h0);
    strb <= 4'hf;
  endtask : s_tick
  task automatic s_svc();
    wr(ST, 32'h10000000, 2'h0);
    rd(ST, 2'h0, d);
    chk(32'(d[28]), 32'h1);
    wr(ST, 32'h08000000, 2'h0);
    chk(32'(svc_p), 32'h0);
    wr(ST, 32'h10000000, 2'h0);
    core.entry_number <= `ESVB_EXC_SVC_PEND;
    core.entry_valid  <= 1'b1;
    @(posedge aclk);
    core.entry_valid  <= 1'b0;
    settle();
    chk(32'(svc_p), 32'h0);
  endtask : s_svc
  task automatic s_vbase();
    logic [31:0] tab [3] = '{32'hffffffff, 32'h20000080, 32'h0000017f};
    for (int i = 0; i < 3; i++) begin
      wr(VB, tab[i], 2'h0);
      rd(VB, 2'h0, d);
      chk(d, tab[i] & `ESVB_VBASE_MASK_NAR);
      chk(vbase, tab[i] & `ESVB_VBASE_MASK_NAR);
      chk(32'(region), 32'(tab[i][29]));
    end
  endtask : s_vbase
  task automatic s_pick();
    pend <= (NEXC'(1) << 20) | (NEXC'(1) << 18);
    prio[20*8+:8] <= 8'h10;
    prio[18*8+:8] <= 8'h40;
    settle();
    chk(32'(highest), 32'd20);
    chk(32'(irq_f), 32'h1);
    core.threshold_priority_mask <= 8'h10;
    settle();
    chk(32'(highest), 32'd0);
    core.threshold_priority_mask <= 8'h00;
    enab[20] <= 1'b0;
    settle();
    chk(32'(highest), 32'd18);
    pend[2] <= 1'b1;
    core.all_fault_block <= 1'b1;
    settle();
    chk(32'(highest), 32'd2);
    pend <= NEXC'(1) << 2;
    core.all_fault_block <= 1'b0;
    settle();
    rd(ST, 2'h0, d);
    chk(32'(d[22]), 32'h0);
    chk(32'(d[17:12]), 32'd2);
    pend <= NEXC'(1) << 20;
  endtask : s_pick
  task automatic s_active();
    core.program_status_exception_field <= 9'h01b;
    act <= NEXC'(1) << (11 + 16);
    rd(ST, 2'h0, d);
    chk({d[23:22], d[11], 2'h0, d[8:0]}, 32'h0000181b);
    act <= (NEXC'(1) << 27) | (NEXC'(1) << 15);
    rd(ST, 2'h0, d);
    chk(32'(d[11]), 32'h0);
    core.program_status_exception_field <= 9'h000;
    act <= '0;
    rd(ST, 2'h0, d);
    chk(32'(d[11:0]), 32'h800);
  endtask : s_active

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, tick_event} = '0;
    {awaddr, araddr, wdata} = '0;
    strb = 4'hf;
    core = '0;
    {pend, act} = '0;
    enab = '1;
    prio = {NEXC{8'h80}};
    n_mismatch = 0;
    num_checks = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    s_reset();
    s_tick();
    s_svc();
    s_vbase();
    s_pick();
    s_active();
    conclude();
  end
endmodule : tb_top
`default_nettype wire
